// file: pkg/imi_pkg.sv
// Constants and types shared by the interrupt mask and in-service block.
package imi_pkg;
   // Register byte addresses (low byte of each 16-bit mask word; +1 is its upper byte).
   localparam logic [31:0] IMI_ADDR_MASK_0   = 32'hFFFFF100;
   localparam logic [31:0] IMI_ADDR_MASK_1   = 32'hFFFFF102;
   localparam logic [31:0] IMI_ADDR_MASK_2   = 32'hFFFFF104;
   localparam logic [31:0] IMI_ADDR_MASK_3   = 32'hFFFFF106;
   localparam logic [31:0] IMI_ADDR_MASK_4   = 32'hFFFFF108;
   localparam logic [31:0] IMI_ADDR_INSERV   = 32'hFFFFF1FA;
   // Geometry.
   localparam int          IMI_NUM_WORDS     = 5;
   localparam int          IMI_NUM_SRC       = 80;
   localparam int          IMI_NUM_LEVELS    = 8;
   // Reset values.
   localparam logic [15:0] IMI_MASK_RESET    = 16'hFFFF;
   localparam logic [7:0]  IMI_INSERV_RESET  = 8'h00;
   // Bits that have no source behind them; they stay at one.
   localparam logic [79:0] IMI_ABSENT_BITS   = {16'hFC00, 16'h01E0, 16'h00F0, 16'h0000, 16'h0000};
   // Access size codes on the register port.
   typedef enum logic [1:0] {
      IMI_SIZE_BYTE,
      IMI_SIZE_HALF,
      IMI_SIZE_BIT
   } imi_size_t;
endpackage

// file: test/imi_cpu_model.sv
// Behavioural core that acknowledges and returns from interrupts on command.
`timescale 1ns/1ps
module imi_cpu_model (
   input  wire logic sys_clk,             // Clock.
   input  wire logic nrst,                // Reset, low.
   input  wire logic irq_valid,           // Request presented.
   input  wire logic maskable_block_flag, // Block flag.
   input  wire logic go_ack,              // Take the next request.
   input  wire logic go_ret,              // Execute a return.
   input  wire logic go_exc,              // Return ends an exception.
   input  wire logic go_ei,               // Enable instruction.
   input  wire logic go_di,               // Disable instruction.
   output logic      cpu_ack,             // Acknowledge pulse.
   output logic      cpu_return_from_interrupt,            // Return pulse.
   output logic      cpu_ret_exc,         // Return qualifier.
   output logic      cpu_set_block,       // Disable pulse.
   output logic      cpu_clr_block        // Enable pulse.
);
   // The core never acknowledges while blocked, and not twice in a row.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         {cpu_ack, cpu_return_from_interrupt, cpu_ret_exc, cpu_set_block, cpu_clr_block} <= 5'h00;
      end else begin
         cpu_ack       <= go_ack & irq_valid & !maskable_block_flag & !cpu_ack;
         cpu_return_from_interrupt      <= go_ret;
         cpu_ret_exc   <= go_exc;
         cpu_set_block <= go_di;
         cpu_clr_block <= go_ei;
      end
   end
endmodule

// file: test/imi_top_props.sv
// Concurrent checks on the ports of the interrupt mask and in-service block.
`timescale 1ns/1ps
module imi_top_props
   import imi_pkg::*;
#(
   parameter int NSRC = IMI_NUM_SRC  // Mask bit count.
)(
   input wire logic            sys_clk,             // Clock.
   input wire logic            nrst,                // Reset, low.
   input wire logic            reg_rd,              // Read strobe.
   input wire logic [15:0]     reg_rdata,           // Read data.
   input wire logic [NSRC-1:0] src_mask_wr,         // View strobes.
   input wire logic [NSRC-1:0] src_mask_wdata,      // View data.
   input wire logic [NSRC-1:0] source_mask_bit,     // Mask storage.
   input wire logic [NSRC-1:0] src_pending,         // Pending flags.
   input wire logic            cpu_ack,             // Acknowledge.
   input wire logic            cpu_return_from_interrupt,            // Return.
   input wire logic            cpu_ret_exc,         // Exception return.
   input wire logic            irq_valid,           // Presented.
   input wire logic [6:0]      irq_src,             // Presented source.
   input wire logic [2:0]      irq_level,           // Presented level.
   input wire logic            ack_taken,           // Taken pulse.
   input wire logic [6:0]      ack_src,             // Taken source.
   input wire logic            maskable_block_flag, // Block flag.
   input wire logic [7:0]      in_service_levels    // Levels.
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   // The two steps of servicing: a taken acknowledge, then a plain return.
   sequence s_ack;
      cpu_ack && irq_valid;
   endsequence
   sequence s_ret;
      cpu_return_from_interrupt && !cpu_ret_exc && !cpu_ack;
   endsequence
   ack_level_a: assert property (s_ack |=> ack_taken && in_service_levels[$past(irq_level)])
      else $error("acknowledge left its level clear");
   ack_src_a: assert property (s_ack |=> ack_src == $past(irq_src))
      else $error("acknowledged source differs");
   ack_block_a: assert property (s_ack |=> maskable_block_flag)
      else $error("block flag not set by acknowledge");
   no_ack_a: assert property (!(cpu_ack && irq_valid) |=> !ack_taken)
      else $error("acknowledge pulse without cause");
   shown_unmasked_a: assert property (irq_valid |-> !source_mask_bit[irq_src] && src_pending[irq_src])
      else $error("masked or idle source presented");
   absent_one_a: assert property ((source_mask_bit & IMI_ABSENT_BITS) == IMI_ABSENT_BITS)
      else $error("absent mask bit cleared");
   ret_lowest_a: assert property (s_ret |=>
      in_service_levels == ($past(in_service_levels) & ($past(in_service_levels) - 8'h01)))
      else $error("return cleared the wrong level");
   exc_keep_a: assert property (cpu_return_from_interrupt && cpu_ret_exc && !cpu_ack |=> $stable(in_service_levels))
      else $error("exception return changed levels");
   quiet_levels_a: assert property (!cpu_ack && !cpu_return_from_interrupt |=> $stable(in_service_levels))
      else $error("levels changed without cause");
   ctrl_view_a: assert property (src_mask_wr[16] |=> source_mask_bit[16] == $past(src_mask_wdata[16]))
      else $error("control view write lost");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
endmodule

// file: test/imi_top_tb_top.sv
// Self-checking bench for the interrupt mask and in-service block.
`timescale 1ns/1ps
module imi_top_tb_top;
   import imi_pkg::*;
   logic         sys_clk, nrst, reg_wr, reg_rd, cpu_ack, cpu_return_from_interrupt, cpu_ret_exc;
   logic         cpu_set_block, cpu_clr_block, irq_valid, ack_taken, maskable_block_flag;
   logic         go_ack, go_ret, go_exc, go_ei, go_di;
   logic [31:0]  reg_addr;
   logic [15:0]  reg_wdata, reg_rdata;
   imi_size_t    reg_size;
   logic [2:0]   reg_bitsel, irq_level;
   logic [6:0]   irq_src, ack_src;
   logic [7:0]   in_service_levels;
   logic [79:0]  src_mask_wr, src_mask_wdata, source_mask_bit, src_pending;
   logic [239:0] src_prio;
   int           n_errors, samples_checked;

   imi_top uut (.*);
   imi_cpu_model core (.*);

   // Free-running 100 MHz clock.
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One register cycle; for a read, d is the expected data.
   task automatic acc(input logic w, input logic [31:0] a, input imi_size_t s,
                      input logic [2:0] b, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr     <= w;
      reg_rd     <= !w;
      reg_addr   <= a;
      reg_size   <= s;
      reg_bitsel <= b;
      reg_wdata  <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      if (!w) chk(reg_rdata, d);
   endtask

   // Pulse return, enable or disable on the core and let it land.
   task automatic cmd(input logic [2:0] c, input logic e);
      @(posedge sys_clk);
      {go_ret, go_ei, go_di} <= c;
      go_exc <= e;
      @(posedge sys_clk);
      {go_ret, go_ei, go_di} <= 3'b000;
      @(posedge sys_clk);
      #1;
   endtask

   // Enable, then wait a bounded time for the core to take a request.
   task automatic take(input logic [6:0] s, input logic [7:0] lv);
      int i;
      cmd(3'b010, 1'b0);
      go_ack <= 1'b1;
      for (i = 0; i < 20 && ack_taken !== 1'b1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      go_ack <= 1'b0;
      if (i == 20) begin
         n_errors++;
         $display("mismatch at %0t: acknowledge timeout", $time);
         tally_and_finish();
      end
      chk({9'h000, ack_src}, {9'h000, s});
      chk({8'h00, in_service_levels}, {8'h00, lv});
      chk({15'h0000, maskable_block_flag}, 16'h0001);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Main sequence.
   initial begin
      {nrst, reg_wr, reg_rd, go_ack, go_ret, go_exc, go_ei, go_di} = 8'h00;
      {reg_addr, reg_wdata, reg_bitsel} = '0;
      reg_size = IMI_SIZE_HALF;
      {src_mask_wr, src_mask_wdata, src_pending} = '0;
      src_prio = '1;
      n_errors = 0;
      samples_checked = 0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      for (int w = 0; w < 5; w++) acc(0, IMI_ADDR_MASK_0 + 2 * w, IMI_SIZE_HALF, 0, 16'hFFFF);
      acc(0, IMI_ADDR_INSERV, IMI_SIZE_BYTE, 0, 16'h0000);
      $display("test reset done");
      for (int w = 0; w < 5; w++) begin
         acc(1, IMI_ADDR_MASK_0 + 2 * w, IMI_SIZE_HALF, 0, 16'h0000);
         acc(0, IMI_ADDR_MASK_0 + 2 * w, IMI_SIZE_HALF, 0, IMI_ABSENT_BITS[16*w+:16]);
      end
      $display("test words done");
      acc(1, IMI_ADDR_MASK_1 + 1, IMI_SIZE_BYTE, 0, 16'h00A5);
      acc(0, IMI_ADDR_MASK_1, IMI_SIZE_HALF, 0, 16'hA500);
      acc(1, IMI_ADDR_MASK_1 + 1, IMI_SIZE_BIT, 3'd1, 16'h0001);
      acc(0, IMI_ADDR_MASK_1 + 1, IMI_SIZE_BIT, 3'd1, 16'h0001);
      acc(0, IMI_ADDR_MASK_1 + 1, IMI_SIZE_BYTE, 0, 16'h00A7);
      @(posedge sys_clk);
      src_mask_wr[16]    <= 1'b1;
      src_mask_wdata[16] <= 1'b1;
      @(posedge sys_clk);
      src_mask_wr[16] <= 1'b0;
      acc(0, IMI_ADDR_MASK_1, IMI_SIZE_HALF, 0, 16'hA701);
      acc(1, IMI_ADDR_INSERV, IMI_SIZE_BYTE, 0, 16'h00FF);
      acc(0, IMI_ADDR_INSERV, IMI_SIZE_BYTE, 0, 16'h0000);
      acc(0, 32'hFFFFF10A, IMI_SIZE_HALF, 0, 16'h0000);
      $display("test access done");
      acc(1, IMI_ADDR_MASK_4, IMI_SIZE_HALF, 0, 16'hFFFF);
      src_prio[15+:3]  <= 3'd3;
      src_prio[6+:3]   <= 3'd1;
      src_prio[192+:3] <= 3'd0;
      src_pending[64]  <= 1'b1;
      src_pending[5]   <= 1'b1;
      take(7'd5, 8'h08);
      src_pending[5] <= 1'b0;
      src_pending[2] <= 1'b1;
      take(7'd2, 8'h0A);
      src_pending[2] <= 1'b0;
      cmd(3'b100, 1'b1);
      chk({8'h00, in_service_levels}, 16'h000A);
      cmd(3'b100, 1'b0);
      chk({8'h00, in_service_levels}, 16'h0008);
      cmd(3'b100, 1'b0);
      chk({8'h00, in_service_levels}, 16'h0000);
      $display("test service done");
      cmd(3'b010, 1'b0);
      chk({15'h0000, maskable_block_flag}, 16'h0000);
      cmd(3'b001, 1'b0);
      chk({15'h0000, maskable_block_flag}, 16'h0001);
      $display("test block flag done");
      tally_and_finish();
   end
endmodule

bind imi_top imi_top_props #(.NSRC(NSRC)) u_props (.*);

// file: verilog/imi_inservice.sv
// In-service level tracker: set on acknowledge, highest-priority (lowest set) level cleared on return.
`timescale 1ns/1ps
module imi_inservice
   import imi_pkg::*;
(
   input  wire logic       sys_clk,    // System clock.
   input  wire logic       nrst,       // Asynchronous reset, active low.
   input  wire logic       ack,        // Maskable acknowledge pulse.
   input  wire logic [2:0] ack_level,  // Priority level of acknowledged source.
   input  wire logic       ret,        // Return from maskable servicing.
   output logic      [7:0] levels      // In-service level bits.
);
   logic [7:0] clr_vec;

   // Level 0 is highest priority, so the lowest set bit is cleared.
   always_comb begin
      clr_vec = 8'h00;
      for (int i = IMI_NUM_LEVELS - 1; i >= 0; i--) begin
         if (levels[i]) begin
            clr_vec = 8'h01 << i;
         end
      end
   end

   // Set wins over clear so an acknowledge in a return cycle is kept.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         levels <= IMI_INSERV_RESET; // R12
      end else begin
         levels <= (levels & ~(ret ? clr_vec : 8'h00)) // R9
                   | (ack ? (8'h01 << ack_level) : 8'h00); // R8 R15
      end
   end
endmodule

// file: verilog/imi_pick.sv
// Picks the highest-priority unmasked pending request.
`timescale 1ns/1ps
module imi_pick
   import imi_pkg::*;
#(
   parameter int NSRC = IMI_NUM_SRC  // Number of request sources.
)(
   input  wire logic [NSRC-1:0]   pend,    // Pending request flags.
   input  wire logic [NSRC-1:0]   mask,    // Mask bits, one masks.
   input  wire logic [3*NSRC-1:0] prio,    // Three-bit priority per source.
   output logic                   valid,   // A request is presentable.
   output logic [6:0]             src,     // Chosen source index.
   output logic [2:0]             level    // Chosen source level.
);
   // Lower level value wins; on a tie the lower index wins.
   always_comb begin
      valid = 1'b0;
      src   = 7'h00;
      level = 3'h7;
      for (int i = 0; i < NSRC; i++) begin
         if (pend[i] && !mask[i] && (!valid || prio[3*i +: 3] < level)) begin // R6 R17
            valid = 1'b1;
            src   = 7'(i);
            level = prio[3*i +: 3];
         end
      end
   end
endmodule

// file: verilog/imi_top.sv
// Mask bank, acknowledge path and in-service register of the interrupt controller.
// What this block does
// (R1) Mask bank shares storage with source control.
// (R2) Mask words readable and writable as halfwords.
// (R3) Upper and lower bytes separately byte/bit accessible.
// (R4) Upper byte bits 0-7 are word bits 8-15.
// (R5) Mask words reset to all ones.
// (R6) Mask zero allows, mask one blocks servicing.
// (R7) Software keeps absent bits written as one.
// (R8) Acknowledge sets the request's level bit.
// (R9) Return clears only highest-priority set level.
// (R10) Non-maskable or exception return leaves levels alone.
// (R11) In-service register read-only, byte or bit.
// (R12) In-service register resets to zero.
// (R13) Software should disable interrupts before reading levels.
// (R14) Acknowledge sets the maskable block flag.
// (R15) Three-bit source priority selects in-service bit.
// (R16) Absent source bits read one, stay masked.
// (R17) Masked requests stay pending, never presented.
`timescale 1ns/1ps
module imi_top
   import imi_pkg::*;
#(
   parameter int NSRC = IMI_NUM_SRC  // Number of mask bits across all words.
)(
   input  wire logic              sys_clk,        // System clock, 100 MHz.
   input  wire logic              nrst,           // Asynchronous reset, active low.
   // Register port.
   input  wire logic [31:0]       reg_addr,       // Byte address.
   input  wire logic [15:0]       reg_wdata,      // Write data, byte data in low bits.
   input  wire logic              reg_wr,         // Write strobe.
   input  wire logic              reg_rd,         // Read strobe.
   input  wire imi_size_t         reg_size,       // Access size.
   input  wire logic [2:0]        reg_bitsel,     // Bit number for single-bit access.
   output logic      [15:0]       reg_rdata,      // Read data, one cycle after strobe.
   // Per-source control register view of each mask bit.
   input  wire logic [NSRC-1:0]   src_mask_wr,    // Write strobe per source mask bit.
   input  wire logic [NSRC-1:0]   src_mask_wdata, // Value written through control view.
   output logic      [NSRC-1:0]   source_mask_bit,// Shared mask storage.
   // Requests and priorities.
   input  wire logic [NSRC-1:0]   src_pending,    // Pending flags from sources.
   input  wire logic [3*NSRC-1:0] src_prio,       // Three-bit priority per source.
   // CPU core side.
   input  wire logic              cpu_ack,        // Core takes the presented request.
   input  wire logic              cpu_return_from_interrupt,       // Return from interrupt executed.
   input  wire logic              cpu_ret_exc,    // That return ends NMI or exception.
   input  wire logic              cpu_set_block,  // Disable instruction.
   input  wire logic              cpu_clr_block,  // Enable instruction.
   output logic                   irq_valid,      // Request presented for acknowledge.
   output logic      [6:0]        irq_src,        // Presented source index.
   output logic      [2:0]        irq_level,      // Presented priority level.
   output logic                   ack_taken,      // Pulse: request acknowledged.
   output logic      [6:0]        ack_src,        // Source that was acknowledged.
   output logic                   maskable_block_flag, // Blocks maskable acknowledge.
   output logic      [7:0]        in_service_levels    // Levels under service.
);
   // Refuse a mask width that the five-word register map cannot address.
   if (NSRC != 16 * IMI_NUM_WORDS) begin
      $error("imi_top: NSRC must equal sixteen times the mask word count");
   end

   logic [NSRC-1:0] next_mask;
   logic            cand_valid;
   logic [6:0]      cand_src;
   logic [2:0]      cand_level;
   logic            ack_ok;
   logic [2:0]      hit_word;
   logic            hit_mask;
   logic            hit_upper;
   logic            hit_inserv;
   logic [15:0]     next_rdata;

   // Decodes a byte address onto a mask word; used by both read and write paths.
   function automatic logic [3:0] decode_mask(input logic [31:0] a);
      decode_mask = 4'h0;
      for (int w = 0; w < IMI_NUM_WORDS; w++) begin
         if (a[31:1] == IMI_ADDR_MASK_0[31:1] + 31'(w)) begin
            decode_mask = {1'b1, 3'(w)};
         end
      end
   endfunction

   // Address decode shared by reads and writes.
   always_comb begin
      logic [3:0] dec;
      dec        = decode_mask(reg_addr);
      hit_mask   = dec[3];
      hit_word   = dec[2:0];
      hit_upper  = reg_addr[0];
      hit_inserv = (reg_addr == IMI_ADDR_INSERV);
   end

   // Next mask value: register port first, then control-register view.
   always_comb begin
      logic [15:0] cur;
      logic [15:0] upd;
      next_mask = source_mask_bit;
      cur       = 16'h0000;
      upd       = 16'h0000;
      if (reg_wr && hit_mask) begin
         cur = source_mask_bit[16*hit_word +: 16];
         upd = cur;
         unique case (reg_size)
            IMI_SIZE_HALF: upd = reg_wdata; // R2
            IMI_SIZE_BYTE: begin
               if (hit_upper) upd[15:8] = reg_wdata[7:0]; // R3 R4
               else           upd[7:0]  = reg_wdata[7:0]; // R3
            end
            IMI_SIZE_BIT: upd[{hit_upper, reg_bitsel}] = reg_wdata[0]; // R3 R4
            default: upd = cur;
         endcase
         next_mask[16*hit_word +: 16] = upd;
      end
      // Control-register writes land in the same storage bits.
      for (int i = 0; i < NSRC; i++) begin
         if (src_mask_wr[i]) next_mask[i] = src_mask_wdata[i]; // R1
      end
      next_mask = next_mask | IMI_ABSENT_BITS; // R16
   end

   // Shared mask storage; absent bits are forced to one so they never unmask.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         source_mask_bit <= {IMI_NUM_WORDS{IMI_MASK_RESET}}; // R5
      end else begin
         source_mask_bit <= next_mask; // R1
      end
   end

   // Highest-priority unmasked pending source.
   imi_pick #(.NSRC(NSRC)) u_pick (
      .pend  (src_pending),
      .mask  (source_mask_bit),
      .prio  (src_prio),
      .valid (cand_valid),
      .src   (cand_src),
      .level (cand_level)
   );

   // Presentation is gated by the block flag so a serviced request cannot nest.
   always_comb begin
      irq_valid = cand_valid && !maskable_block_flag; // R17
      irq_src   = cand_src;
      irq_level = cand_level;
      ack_ok    = cpu_ack && irq_valid;
   end

   // Acknowledge report to the sources, registered.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ack_taken <= 1'b0;
         ack_src   <= 7'h00;
      end else begin
         ack_taken <= ack_ok;
         if (ack_ok) ack_src <= cand_src;
      end
   end

   // Block flag: starts set after reset; acknowledge or disable sets it, enable clears it.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         maskable_block_flag <= 1'b1;
      end else if (ack_ok || cpu_set_block) begin
         maskable_block_flag <= 1'b1; // R14
      end else if (cpu_clr_block) begin
         maskable_block_flag <= 1'b0;
      end
   end

   // In-service tracker; returns from NMI or exceptions do not clear a level.
   imi_inservice u_inserv (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .ack       (ack_ok),
      .ack_level (cand_level),
      .ret       (cpu_return_from_interrupt && !cpu_ret_exc), // R10
      .levels    (in_service_levels)
   );

   // Read mux; writes to the in-service address fall through with no effect.
   always_comb begin
      logic [15:0] word;
      logic [7:0]  sel;
      word       = source_mask_bit[16*hit_word +: 16];
      sel        = hit_upper ? word[15:8] : word[7:0]; // R4
      next_rdata = 16'h0000;
      if (hit_mask) begin
         unique case (reg_size)
            IMI_SIZE_HALF: next_rdata = word; // R2
            IMI_SIZE_BYTE: next_rdata = {8'h00, sel}; // R3
            IMI_SIZE_BIT:  next_rdata = {15'h0000, sel[reg_bitsel]}; // R3
            default:       next_rdata = 16'h0000;
         endcase
      end else if (hit_inserv) begin
         unique case (reg_size)
            IMI_SIZE_BIT: next_rdata = {15'h0000, in_service_levels[reg_bitsel]}; // R11
            default:      next_rdata = {8'h00, in_service_levels}; // R11
         endcase
      end
   end

   // Read data holds only in the cycle after the read strobe.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 16'h0000;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : 16'h0000;
      end
   end
endmodule
